// file: core/swc_sleep_wakeup_controller.sv
// Sleep and wake-up controller with APB register access
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps

module swc_sleep_wakeup_controller
  import swc_pkg::*;
#(
  parameter int          WDOG_WIDTH = SWC_WDOG_WIDTH,
  parameter int          PIO_WIDTH  = 8,
  parameter int          PC_WIDTH   = 13,
  parameter int unsigned OST_CYCLES = SWC_OST_CYCLES
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  sleep_exec,
  input  wire logic                  clr_wdog_exec,
  input  wire logic [PC_WIDTH-1:0]   core_pc,
  input  wire logic                  master_clear_pin,
  input  wire logic                  external_edge_irq_pin,
  input  wire logic                  port_change_evt,
  input  wire logic                  comparator_evt,
  input  wire logic                  wdog_tick,
  input  wire logic [PIO_WIDTH-1:0]  pio_out_core,
  input  wire logic [PIO_WIDTH-1:0]  pio_oe_core,
  output logic      [PIO_WIDTH-1:0]  pio_out,
  output logic      [PIO_WIDTH-1:0]  pio_oe,
  output logic                       osc_drive_en,
  output logic                       core_clk_en,
  output logic                       core_reset_req,
  output logic                       master_clear_pin_o,
  output logic                       master_clear_pin_oe,
  output logic                       prefetch_req,
  output logic      [PC_WIDTH-1:0]   prefetch_addr,
  output logic                       wdog_reset_req,
  output swc_resume_t                resume_cmd
);

  typedef enum logic [1:0]
  {
    SWC_RUN,
    SWC_SLEEP,
    SWC_OST,
    SWC_RESUME
  } swc_state_t;

  swc_state_t                state_reg;
  swc_state_t                state_next;
  logic [6:0]                ctrl_reg;
  logic                      power_down_flag_n;
  logic                      timeout_flag_n;
  logic [SWC_NUM_IRQ-1:0]    irq_flag_reg;
  logic [WDOG_WIDTH-1:0]     watchdog_counter;
  logic                      ext_pin_reg;
  logic [PIO_WIDTH-1:0]      pio_out_reg;
  logic [PIO_WIDTH-1:0]      pio_oe_reg;
  logic [31:0]               ost_cnt_reg;
  swc_cause_t                cause_reg;
  logic                      gie_at_wake_reg;
  logic [PC_WIDTH-1:0]       prefetch_addr_reg;
  logic                      prefetch_req_reg;
  logic                      core_reset_reg;
  logic                      wdog_reset_reg;
  swc_resume_t               resume_reg;

  // Bus decode
  wire logic                 bus_access = psel & penable & clk_en;
  wire logic                 bus_wr     = bus_access & pwrite;
  wire logic                 hit_ctrl   = (paddr == SWC_OFF_CTRL);
  wire logic                 hit_status = (paddr == SWC_OFF_STATUS);
  wire logic                 hit_irq    = (paddr == SWC_OFF_IRQ);
  wire logic                 hit_wdog   = (paddr == SWC_OFF_WDOG);
  wire logic                 hit_any    = hit_ctrl | hit_status | hit_irq | hit_wdog;
  wire logic                 wr_ctrl    = bus_wr & hit_ctrl;
  wire logic                 wr_irq     = bus_wr & hit_irq;

  wire logic                 global_irq_enable        = ctrl_reg[SWC_CTRL_GIE];
  wire logic                 wd_enabled = ctrl_reg[SWC_CTRL_WD_EN];
  wire swc_osc_mode_t        osc_mode   =
    swc_osc_mode_t'(ctrl_reg[SWC_CTRL_OSC_HI:SWC_CTRL_OSC_LO]);
  wire logic [SWC_NUM_IRQ-1:0] irq_en   =
    ctrl_reg[SWC_CTRL_CMP_EN:SWC_CTRL_EXT_EN];

  wire logic ext_edge = external_edge_irq_pin & ~ext_pin_reg;
  wire logic [SWC_NUM_IRQ-1:0] irq_evt = {comparator_evt, port_change_evt, ext_edge};

  wire logic wdog_max     = &watchdog_counter;
  wire logic wdog_timeout = wd_enabled & wdog_tick & wdog_max;

  wire logic asleep = (state_reg != SWC_RUN);
  wire logic sleep_entry = (state_reg == SWC_RUN) & sleep_exec;

  wire swc_wake_t wake_src = '{
    master_clear: ~master_clear_pin,
    wdog_timeout: wdog_timeout,
    irq_pending:  |(irq_flag_reg & irq_en)
  };
  wire logic wake_req = wake_src.master_clear | wake_src.wdog_timeout | wake_src.irq_pending;
  wire logic is_rc    = (osc_mode == SWC_OSC_RC);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SWC_RUN:
      begin
        if (sleep_exec)
          state_next = SWC_SLEEP;
      end
      SWC_SLEEP:
      begin
        // pending flag wakes; RC skips start-up
        if (wake_req)
          state_next = (is_rc || wake_src.master_clear) ? SWC_RESUME : SWC_OST;
      end
      SWC_OST:
      begin
        if (ost_cnt_reg >= OST_CYCLES - 1)
          state_next = SWC_RESUME;
      end
      SWC_RESUME:
        state_next = SWC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= SWC_RUN;
    else if (clk_en)
      state_reg <= state_next;
  end

  // Start-up counter only runs in the start-up state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ost_cnt_reg <= 32'h0000_0000;
    else if (clk_en)
      ost_cnt_reg <= (state_reg == SWC_OST) ? ost_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
  end

  // Wake cause latched at the wake decision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_reg       <= SWC_CAUSE_NONE;
      gie_at_wake_reg <= 1'b0;
    end
    else if (clk_en && state_reg == SWC_SLEEP && wake_req)
    begin
      cause_reg <= wake_src.master_clear ? SWC_CAUSE_MASTER_CLEAR_PIN :
                   wake_src.wdog_timeout ? SWC_CAUSE_WDOG : SWC_CAUSE_IRQ;
      // global enable does not gate wake
      gie_at_wake_reg <= global_irq_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= SWC_CTRL_RESET;
    else if (clk_en && wr_ctrl)
      ctrl_reg <= pwdata[6:0];
  end

  // Interrupt flags: event set wins over write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < SWC_NUM_IRQ; gi++)
    begin : g_irq
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          irq_flag_reg[gi] <= 1'b0;
        else if (clk_en)
        begin
          if (irq_evt[gi])
            irq_flag_reg[gi] <= 1'b1;
          else if (wr_irq && pwdata[gi])
            irq_flag_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_pin_reg <= 1'b0;
    else if (clk_en)
      ext_pin_reg <= external_edge_irq_pin;
  end

  // Watchdog keeps counting asleep; cleared on entry, wake and clear instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_counter <= '0;
    else if (clk_en)
    begin
      if (sleep_entry || clr_wdog_exec || !wd_enabled)
        watchdog_counter <= '0;
      else if (state_reg == SWC_SLEEP && wake_req)
        watchdog_counter <= '0;
      else if (wdog_tick)
        watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // Status flags; power-up reset sets both
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_down_flag_n <= 1'b1;
      timeout_flag_n    <= 1'b1;
    end
    else if (clk_en)
    begin
      if (sleep_entry || clr_wdog_exec)
      begin
        power_down_flag_n <= ~sleep_entry;
        timeout_flag_n    <= 1'b1;
      end
      else if (wdog_timeout)
        timeout_flag_n <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pio_out_reg <= '0;
      pio_oe_reg  <= '0;
    end
    else if (clk_en && !asleep && !sleep_entry)
    begin
      pio_out_reg <= pio_out_core;
      pio_oe_reg  <= pio_oe_core;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prefetch_req_reg  <= 1'b0;
      prefetch_addr_reg <= '0;
    end
    else if (clk_en)
    begin
      prefetch_req_reg <= sleep_entry;
      if (sleep_entry)
        prefetch_addr_reg <= core_pc + 1'b1;
    end
  end

  // Resume and reset pulses toward the sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset_reg <= 1'b0;
      wdog_reset_reg <= 1'b0;
      resume_reg     <= '0;
    end
    else if (clk_en)
    begin
      core_reset_reg <= (state_reg == SWC_RESUME) && (cause_reg == SWC_CAUSE_MASTER_CLEAR_PIN);
      wdog_reset_reg <= !asleep && wdog_timeout;
      // resume, vector on an interrupt wake with global enable set
      resume_reg.resume    <= (state_reg == SWC_RESUME) && (cause_reg != SWC_CAUSE_MASTER_CLEAR_PIN);
      resume_reg.do_vector <= (state_reg == SWC_RESUME) && (cause_reg == SWC_CAUSE_IRQ)
                              && gie_at_wake_reg;
      resume_reg.vector    <= SWC_IRQ_VECTOR;
    end
  end

  // Register read mux
  wire logic [31:0] rd_status = {26'h0, cause_reg, 1'b0, asleep,
                                 timeout_flag_n, power_down_flag_n};
  wire logic [31:0] rd_data =
    hit_ctrl   ? {25'h0, ctrl_reg} :
    hit_status ? rd_status :
    hit_irq    ? {29'h0, irq_flag_reg} :
    hit_wdog   ? 32'(watchdog_counter) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite)
      prdata <= rd_data;
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  assign osc_drive_en        = ~(state_reg == SWC_SLEEP);
  assign core_clk_en         = ~asleep;
  assign pio_out             = pio_out_reg;
  assign pio_oe              = pio_oe_reg;
  assign master_clear_pin_o  = 1'b0;
  assign master_clear_pin_oe = 1'b0;
  assign prefetch_req        = prefetch_req_reg;
  assign prefetch_addr       = prefetch_addr_reg;
  assign core_reset_req      = core_reset_reg;
  assign wdog_reset_req      = wdog_reset_reg;
  assign resume_cmd          = resume_reg;

  // Assertions
  sequence s_wake_seen;
    (state_reg == SWC_SLEEP) && wake_req;
  endsequence

  chk_sleep_entry_only: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state_reg == SWC_RUN && !sleep_exec |=> state_reg == SWC_RUN)
    else $error("sleep entered without instruction");
  chk_flags_on_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sleep_entry |=> !power_down_flag_n && timeout_flag_n)
    else $error("status flags wrong after sleep");
  chk_wdog_clear_entry: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sleep_entry |=> watchdog_counter == '0)
    else $error("watchdog not cleared on sleep");
  chk_osc_off_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == SWC_SLEEP |-> !osc_drive_en && !core_clk_en)
    else $error("oscillator running in sleep");
  chk_pins_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && asleep |=> $stable(pio_out) && $stable(pio_oe))
    else $error("pins changed in sleep");
  chk_master_clear_pin_not_driven: assert property (@(posedge pclk) disable iff (!presetn)
    !master_clear_pin_oe)
    else $error("master clear pin driven");
  chk_wdog_wake_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en and s_wake_seen) |=> watchdog_counter == '0)
    else $error("watchdog not cleared on wake");
  chk_rc_no_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en and s_wake_seen and is_rc) |=> state_reg == SWC_RESUME)
    else $error("start-up delay in RC mode");
  chk_timeout_flag_wd: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wdog_timeout && !sleep_entry && !clr_wdog_exec |=> !timeout_flag_n)
    else $error("time-out flag not cleared");
  chk_prefetch_addr: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && sleep_entry |=> prefetch_req && prefetch_addr == $past(core_pc) + 1'b1)
    else $error("prefetch address wrong");

endmodule

// file: pkg/swc_pkg.sv
// Package for the sleep and wake-up controller: register map, fields, oscillator modes, wake causes, timing
package swc_pkg;

  // APB register byte offsets
  localparam logic [7:0] SWC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SWC_OFF_STATUS = 8'h04;
  localparam logic [7:0] SWC_OFF_IRQ    = 8'h08;
  localparam logic [7:0] SWC_OFF_WDOG   = 8'h0C;

  // Control register fields
  localparam int SWC_CTRL_GIE    = 0;
  localparam int SWC_CTRL_EXT_EN = 1;
  localparam int SWC_CTRL_PRT_EN = 2;
  localparam int SWC_CTRL_CMP_EN = 3;
  localparam int SWC_CTRL_WD_EN  = 4;
  localparam int SWC_CTRL_OSC_LO = 5;
  localparam int SWC_CTRL_OSC_HI = 6;

  // Status register fields
  localparam int SWC_ST_PD_N   = 0;
  localparam int SWC_ST_TO_N   = 1;
  localparam int SWC_ST_SLEEP  = 2;
  localparam int SWC_ST_CAUSE0 = 4;

  // Interrupt flag register: write one clears
  localparam int SWC_IRQ_EXT = 0;
  localparam int SWC_IRQ_PRT = 1;
  localparam int SWC_IRQ_CMP = 2;
  localparam int SWC_NUM_IRQ = 3;

  localparam logic [6:0] SWC_CTRL_RESET = 7'h00;

  // Interrupt vector address
  localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;

  // Oscillator start-up: 1024 oscillator periods
  localparam int SWC_OST_TOSC        = 1024;
  localparam int SWC_CLK_PERIOD_NS   = 20;
  localparam int SWC_OSC_PERIOD_NS   = 20;
  localparam int SWC_OST_CYCLES      =
    (SWC_OST_TOSC * SWC_OSC_PERIOD_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;
  localparam int SWC_WDOG_WIDTH      = 16;

  typedef enum logic [1:0]
  {
    SWC_OSC_LP,
    SWC_OSC_XT,
    SWC_OSC_HS,
    SWC_OSC_RC
  } swc_osc_mode_t;

  typedef enum logic [1:0]
  {
    SWC_CAUSE_NONE,
    SWC_CAUSE_MASTER_CLEAR_PIN,
    SWC_CAUSE_WDOG,
    SWC_CAUSE_IRQ
  } swc_cause_t;

  // Wake-up sources bundled together
  typedef struct packed
  {
    logic master_clear;
    logic wdog_timeout;
    logic irq_pending;
  } swc_wake_t;

  // Resume command to the core sequencer
  typedef struct packed
  {
    logic        resume;
    logic        do_vector;
    logic [12:0] vector;
  } swc_resume_t;

endpackage

// file: tb/swc_core_model.sv
// Core sequencer stand-in: issues power-down, advances the PC, churns pin values
`timescale 1ns/1ps
module swc_core_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        core_clk_en,
  input  wire logic        sleep_req,
  output logic             sleep_exec,
  output logic [12:0]      core_pc,
  output logic [7:0]       pio_out_core,
  output logic [7:0]       pio_oe_core
);
  // Pins change every cycle so a missing freeze cannot hide
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sleep_exec   <= 1'b0;
      core_pc      <= 13'h0000;
      pio_out_core <= 8'h5A;
      pio_oe_core  <= 8'h0F;
    end
    else
    begin
      sleep_exec   <= sleep_req & core_clk_en;
      pio_out_core <= pio_out_core + 8'h35;
      pio_oe_core  <= ~pio_oe_core;
      if (core_clk_en)
        core_pc <= core_pc + 13'h0001;
    end
endmodule

// file: tb/swc_sleep_wakeup_controller_tb.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
module swc_sleep_wakeup_controller_tb;
  import swc_pkg::*;
  localparam int OST = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic        sleep_req, sleep_exec, master_clear_pin_pin, ext_pin, port_evt, cmp_evt, wdog_tick;
  logic        osc_drive_en, core_clk_en, core_reset_req, mc_o, mc_oe, prefetch_req;
  logic        wdog_reset_req, res_dov, global_irq_enable;
  logic [1:0]  osc;
  logic [7:0]  paddr, pio_out_core, pio_oe_core, pio_out, pio_oe;
  logic [12:0] core_pc, pc_at, pf_addr, res_vec, prefetch_addr_w;
  logic [31:0] pwdata, prdata, q;
  swc_resume_t resume_cmd;
  int          n_errors = 0, checks = 0, n_res = 0, n_rst = 0, n_wrst = 0, cyc, k, s;

  swc_sleep_wakeup_controller #(.WDOG_WIDTH(4), .OST_CYCLES(OST)) dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_exec(sleep_exec), .clr_wdog_exec(1'b0), .core_pc(core_pc),
    .master_clear_pin(master_clear_pin_pin), .external_edge_irq_pin(ext_pin),
    .port_change_evt(port_evt), .comparator_evt(cmp_evt), .wdog_tick(wdog_tick),
    .pio_out_core(pio_out_core), .pio_oe_core(pio_oe_core), .pio_out(pio_out),
    .pio_oe(pio_oe), .osc_drive_en(osc_drive_en), .core_clk_en(core_clk_en),
    .core_reset_req(core_reset_req), .master_clear_pin_o(mc_o),
    .master_clear_pin_oe(mc_oe), .prefetch_req(prefetch_req),
    .prefetch_addr(prefetch_addr_w), .wdog_reset_req(wdog_reset_req),
    .resume_cmd(resume_cmd));

  swc_core_model core_u (.pclk(pclk), .presetn(presetn), .core_clk_en(core_clk_en),
    .sleep_req(sleep_req), .sleep_exec(sleep_exec), .core_pc(core_pc),
    .pio_out_core(pio_out_core), .pio_oe_core(pio_oe_core));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Pulses last one cycle, so they are caught at the edge
  always @(posedge pclk)
  begin
    if (sleep_exec) pc_at <= core_pc;
    if (prefetch_req) pf_addr <= prefetch_addr_w;
    if (resume_cmd.resume) res_dov <= resume_cmd.do_vector;
    if (resume_cmd.resume) res_vec <= resume_cmd.vector;
    if (resume_cmd.resume) n_res <= n_res + 1;
    if (core_reset_req) n_rst <= n_rst + 1;
    if (wdog_reset_req) n_wrst <= n_wrst + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits on pready only; the bench watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sleep_now;
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
  endtask

  task automatic fire(input int src);
    @(posedge pclk);
    if (src == 0) ext_pin <= 1'b1;
    if (src == 1) port_evt <= 1'b1;
    if (src == 2) cmp_evt <= 1'b1;
    @(posedge pclk);
    port_evt <= 1'b0;
    cmp_evt  <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      wdog_tick <= 1'b1;
      @(posedge pclk);
      wdog_tick <= 1'b0;
    end
  endtask

  task automatic wait_wake;
    int r0, s0;
    r0 = n_res;
    s0 = n_rst;
    cyc = 0;
    while (n_res == r0 && n_rst == s0 && cyc < 300)
    begin
      @(negedge pclk);
      cyc++;
    end
  endtask

  task automatic asleep_checks;
    logic [15:0] p;
    repeat (3) @(negedge pclk);
    p = {pio_oe, pio_out};
    chk("osc and core clock", 0, {osc_drive_en, core_clk_en});
    chk("prefetch address", pc_at + 13'h0001, pf_addr);
    repeat (4) @(negedge pclk);
    chk("held pins", p, {pio_oe, pio_out});
    apb(1'b0, SWC_OFF_STATUS, 32'h0);
    chk("status asleep", 32'h6, q & 32'h7);
  endtask

  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, sleep_req, ext_pin, port_evt, cmp_evt} = '0;
    {paddr, pwdata, wdog_tick} = '0;
    master_clear_pin_pin = 1'b1;
    void'($urandom(32'hF0E6));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SWC_OFF_STATUS, 32'h0);
    chk("status at power-up", 32'h3, q & 32'h7);
    fire(1);
    repeat (6) @(negedge pclk);
    chk("awake without sleep", 32'h3, {osc_drive_en, core_clk_en});
    apb(1'b0, SWC_OFF_IRQ, 32'h0);
    chk("flag without enable", 32'h2, q & 32'h7);
    apb(1'b1, SWC_OFF_IRQ, 32'h7);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h1, {q, perr});
    for (s = 0; s < 6; s++)
    begin
      // First two passes pin both start-up paths and both vector choices
      global_irq_enable = (s < 2) ? 1'(1 - s) : 1'($urandom_range(0, 1));
      osc = (s == 0) ? 2'h1 : (s == 1) ? 2'h3 : 2'($urandom_range(0, 3));
      apb(1'b1, SWC_OFF_CTRL, {25'h0, osc, 1'b0, 3'(1 << (s % 3)), global_irq_enable});
      sleep_now;
      asleep_checks;
      k = n_res;
      fire((s + 1) % 3);
      repeat (10) @(negedge pclk);
      chk("no wake when disabled", k, n_res);
      fire(s % 3);
      wait_wake;
      chk("irq resume", k + 1, n_res);
      chk("vector taken", global_irq_enable, res_dov);
      chk("vector address", SWC_IRQ_VECTOR, res_vec);
      chk("start-up wait", osc != 2'h3, cyc >= OST);
      ext_pin <= 1'b0;
      apb(1'b1, SWC_OFF_IRQ, 32'h7);
    end
    // Watchdog disabled: ticks must not wake, master clear must reset
    apb(1'b1, SWC_OFF_CTRL, 32'h60);
    sleep_now;
    tick(20);
    @(negedge pclk);
    chk("disabled watchdog", 0, core_clk_en);
    k = n_res;
    @(posedge pclk);
    master_clear_pin_pin <= 1'b0;
    wait_wake;
    chk("master clear reset", 1, n_rst);
    chk("master clear no resume", k, n_res);
    @(posedge pclk);
    master_clear_pin_pin <= 1'b1;
    apb(1'b1, SWC_OFF_CTRL, 32'h70);
    tick(5);
    sleep_now;
    repeat (3) @(negedge pclk);
    apb(1'b0, SWC_OFF_WDOG, 32'h0);
    chk("watchdog cleared on sleep", 0, q);
    tick(3);
    apb(1'b0, SWC_OFF_WDOG, 32'h0);
    chk("watchdog runs asleep", 3, q);
    k = n_res;
    tick(13);
    wait_wake;
    chk("watchdog resume", k + 1, n_res);
    chk("no watchdog reset", 32'h0, {n_wrst, mc_oe, mc_o});
    apb(1'b0, SWC_OFF_STATUS, 32'h0);
    chk("time-out flag", 0, q & 32'h3);
    apb(1'b0, SWC_OFF_WDOG, 32'h0);
    chk("watchdog cleared on wake", 0, q);
    apb(1'b1, SWC_OFF_CTRL, 32'h68);
    fire(2);
    k = n_res;
    sleep_now;
    wait_wake;
    chk("pending flag wake", k + 1, n_res);
    chk("prompt wake in line", 32'h2, {cyc < OST, res_dov});
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out;
  end
endmodule
